// ==== core/stb_timers.sv ====
// How it works
// - 32-bit down counter; interrupt pulse when its top bit goes 0 to 1, once the counter has been written since reset.
// - reading the down counter returns its live count.
// - down counter untouched by reset; reset clears the timebase enable, so it stops counting.
// - 64-bit timebase counts periodically; only software loads it, upper and lower.
// - timebase register numbers: read 268/269, write 284/285.
// - wrong-direction timebase access leaves it alone and raises emulation trap.
// - decoder flags move-from-timebase by extended opcode 371, not 339.
// - two 32-bit reference registers compared against timebase low; match requests interrupt.
// - reference 0 match sets first flag, reference 1 match sets second.
// - timebase match flags clear on written 1, zero ignored, several at once.
// - timebase request asserted when a flag and its enable are both set.
// - timebase freeze with debug freeze stops timebase and down counter.
// - timebase enable gates counting of timebase and down counter.
// - timebase level field picks which request line is driven.
// - one-second flag set on every second pulse; software clears it.
// - alarm flag set when clock count equals programmed alarm.
// - source select: 0 means 32768 Hz input, 1 means 38400 Hz; reset keeps it.
// - seconds enable and seconds flag assert the clock request.
// - alarm enable and alarm flag assert the clock request.
// - clock freeze with debug freeze stops the real-time clock.
// - clock flags clear on written 1, zero ignored, readable any time.
// - clock level field picks which request line is driven.
// - clock enable gates all clock timers and survives reset; the clock stays stopped after reset until the clock CSR is written.
// - freeze input is the core's debug-mode indicator.
`timescale 1ns/1ps
module stb_timers #(
    parameter int TB_TICK_DIV = stb_pkg::TB_TICK_DIV_DEFAULT,
    parameter logic [9:0] SPR_DOWN_COUNTER = stb_pkg::SPR_DOWN_COUNTER_DEFAULT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic debug_freeze,
    input wire logic rtc_clk_pin,
    input wire stb_pkg::stb_mmio_req_type mmio_req,
    output stb_pkg::stb_rsp_type mmio_rsp,
    input wire stb_pkg::stb_spr_req_type spr_req,
    output stb_pkg::stb_rsp_type spr_rsp,
    output logic spr_emul_trap,
    input wire logic [9:0] insn_xop,
    output logic insn_is_move_from_tb,
    output logic insn_is_move_from_spr,
    output logic dec_irq,
    output logic [7:0] tb_irq_level,
    output logic [7:0] rtc_irq_level
);
    import stb_pkg::*;

    initial begin
        if (TB_TICK_DIV < 1 || TB_TICK_DIV > (1 << TICK_CNT_W)) begin
            $error("TB_TICK_DIV out of range");
        end
    end

    // state cleared by reset
    typedef struct packed {
        logic [7:0] tb_lvl;
        logic m0;
        logic m1;
        logic ie0;
        logic ie1;
        logic timebase_freeze;
        logic timebase_count_enable;
        logic [7:0] rtc_lvl;
        logic sec;
        logic alarm_match_flag;
        logic tick_irq_enable;
        logic ale;
        logic rtclock_freeze;
        logic dec_loaded;
        logic rtc_cfg_loaded;
        logic [TICK_CNT_W-1:0] tick_cnt;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        stb_rsp_type mmio_rsp;
        stb_rsp_type spr_rsp;
        logic trap;
        logic dec_irq;
    } stb_state_type;

    // keep-alive state, never touched by reset
    typedef struct packed {
        logic [31:0] dec;
        logic [63:0] tb;
        logic [31:0] ref0;
        logic [31:0] ref1;
        logic [31:0] rtc_cnt;
        logic [31:0] rtc_alarm;
        logic src_sel;
        logic rtclock_timers_enable;
        logic [15:0] prescale;
    } stb_keep_type;

    stb_state_type st_r;
    stb_state_type st_nxt;
    stb_keep_type kp_r;
    stb_keep_type kp_nxt;

    function automatic logic [7:0] req_level(input logic [7:0] lvl, input logic req);
        req_level = req ? lvl : 8'h00;
    endfunction : req_level

    function automatic logic w1c(input logic flag, input logic set, input logic clr);
        w1c = set | (flag & ~clr);
    endfunction : w1c

    logic tb_run;
    logic rtc_run;
    logic tb_tick;
    logic rtc_edge;
    logic sec_pulse;
    logic [31:0] dec_dn;
    logic [31:0] rtc_next;
    logic match0;
    logic match1;
    logic alarm_hit;
    logic mm_wr;
    logic mm_rd;
    logic sp_wr;
    logic sp_rd;
    logic [15:0] tb_csr_rd;
    logic [15:0] rtc_csr_rd;
    logic [TICK_CNT_W-1:0] tick_last;

    assign tick_last = TICK_CNT_W'(TB_TICK_DIV - 1);
    assign mm_wr = mmio_req.valid & mmio_req.write;
    assign mm_rd = mmio_req.valid & ~mmio_req.write;
    assign sp_wr = spr_req.valid & spr_req.write;
    assign sp_rd = spr_req.valid & ~spr_req.write;

    assign tb_run = st_r.timebase_count_enable & ~(st_r.timebase_freeze & debug_freeze);
    assign tb_tick = tb_run & (st_r.tick_cnt == tick_last);
    assign dec_dn = kp_r.dec - 32'h0000_0001;
    assign match0 = (kp_r.tb[31:0] == kp_r.ref0);
    assign match1 = (kp_r.tb[31:0] == kp_r.ref1);

    assign rtc_run = st_r.rtc_cfg_loaded & kp_r.rtclock_timers_enable & ~(st_r.rtclock_freeze & debug_freeze);
    assign rtc_edge = rtc_run & st_r.pin_s2 & ~st_r.pin_prev;
    assign sec_pulse = rtc_edge & (kp_r.prescale == (kp_r.src_sel ? RTC_DIV_FAST : RTC_DIV_SLOW));
    assign rtc_next = kp_r.rtc_cnt + 32'h0000_0001;
    assign alarm_hit = sec_pulse & (rtc_next == kp_r.rtc_alarm);

    always_comb begin
        tb_csr_rd = 16'h0000;
        tb_csr_rd[CSR_LVL_LSB +: 8] = st_r.tb_lvl;
        tb_csr_rd[CSR_FLAG0] = st_r.m0;
        tb_csr_rd[CSR_FLAG1] = st_r.m1;
        tb_csr_rd[CSR_IE0] = st_r.ie0;
        tb_csr_rd[CSR_IE1] = st_r.ie1;
        tb_csr_rd[CSR_FRZ] = st_r.timebase_freeze;
        tb_csr_rd[CSR_EN] = st_r.timebase_count_enable;
        rtc_csr_rd = 16'h0000;
        rtc_csr_rd[CSR_LVL_LSB +: 8] = st_r.rtc_lvl;
        rtc_csr_rd[CSR_FLAG0] = st_r.sec;
        rtc_csr_rd[CSR_FLAG1] = st_r.alarm_match_flag;
        rtc_csr_rd[CSR_SRC_SEL] = kp_r.src_sel;
        rtc_csr_rd[CSR_IE0] = st_r.tick_irq_enable;
        rtc_csr_rd[CSR_IE1] = st_r.ale;
        rtc_csr_rd[CSR_FRZ] = st_r.rtclock_freeze;
        rtc_csr_rd[CSR_EN] = kp_r.rtclock_timers_enable;
    end

    always_comb begin
        logic tb_csr_wr;
        logic rtc_csr_wr;
        tb_csr_wr = mm_wr & (mmio_req.addr == ADDR_TB_CSR);
        rtc_csr_wr = mm_wr & (mmio_req.addr == ADDR_RTC_CSR);
        st_nxt = st_r;
        kp_nxt = kp_r;

        // timebase tick divider and pin synchroniser
        st_nxt.tick_cnt = !tb_run ? st_r.tick_cnt : (tb_tick ? '0 : st_r.tick_cnt + 1'b1);
        st_nxt.pin_s1 = rtc_clk_pin;
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.pin_prev = st_r.pin_s2;

        // counting
        st_nxt.dec_irq = 1'b0;
        if (tb_tick) begin
            kp_nxt.tb = kp_r.tb + 64'h0000_0000_0000_0001;
            kp_nxt.dec = dec_dn;
            st_nxt.dec_irq = st_r.dec_loaded & ~kp_r.dec[31] & dec_dn[31];
        end
        if (rtc_edge) begin
            kp_nxt.prescale = sec_pulse ? 16'h0000 : kp_r.prescale + 16'h0001;
        end
        if (sec_pulse) begin
            kp_nxt.rtc_cnt = rtc_next;
        end

        // status flags: a set in the same cycle beats a clear
        st_nxt.m0 = w1c(st_r.m0, match0, tb_csr_wr & mmio_req.wdata[CSR_FLAG0]);
        st_nxt.m1 = w1c(st_r.m1, match1, tb_csr_wr & mmio_req.wdata[CSR_FLAG1]);
        st_nxt.sec = w1c(st_r.sec, sec_pulse, rtc_csr_wr & mmio_req.wdata[CSR_FLAG0]);
        st_nxt.alarm_match_flag = w1c(st_r.alarm_match_flag, alarm_hit, rtc_csr_wr & mmio_req.wdata[CSR_FLAG1]);

        // memory-mapped writes
        if (tb_csr_wr) begin
            st_nxt.tb_lvl = mmio_req.wdata[CSR_LVL_LSB +: 8];
            st_nxt.ie0 = mmio_req.wdata[CSR_IE0];
            st_nxt.ie1 = mmio_req.wdata[CSR_IE1];
            st_nxt.timebase_freeze = mmio_req.wdata[CSR_FRZ];
            st_nxt.timebase_count_enable = mmio_req.wdata[CSR_EN];
        end else if (mm_wr && mmio_req.addr == ADDR_TB_REF0) begin
            kp_nxt.ref0 = mmio_req.wdata;
        end else if (mm_wr && mmio_req.addr == ADDR_TB_REF1) begin
            kp_nxt.ref1 = mmio_req.wdata;
        end else if (rtc_csr_wr) begin
            st_nxt.rtc_lvl = mmio_req.wdata[CSR_LVL_LSB +: 8];
            st_nxt.tick_irq_enable = mmio_req.wdata[CSR_IE0];
            st_nxt.ale = mmio_req.wdata[CSR_IE1];
            st_nxt.rtclock_freeze = mmio_req.wdata[CSR_FRZ];
            st_nxt.rtc_cfg_loaded = 1'b1;
            kp_nxt.src_sel = mmio_req.wdata[CSR_SRC_SEL];
            kp_nxt.rtclock_timers_enable = mmio_req.wdata[CSR_EN];
        end else if (mm_wr && mmio_req.addr == ADDR_RTC_COUNT) begin
            kp_nxt.rtc_cnt = mmio_req.wdata;
            // a count write restarts the second, giving the prescaler a known start
            kp_nxt.prescale = 16'h0000;
        end else if (mm_wr && mmio_req.addr == ADDR_RTC_ALARM) begin
            kp_nxt.rtc_alarm = mmio_req.wdata;
        end

        // memory-mapped reads, unmapped offsets read zero
        st_nxt.mmio_rsp.rvalid = mm_rd;
        st_nxt.mmio_rsp.rdata = 32'h0000_0000;
        if (mm_rd) begin
            if (mmio_req.addr == ADDR_TB_CSR) begin
                st_nxt.mmio_rsp.rdata = {16'h0000, tb_csr_rd};
            end else if (mmio_req.addr == ADDR_TB_REF0) begin
                st_nxt.mmio_rsp.rdata = kp_r.ref0;
            end else if (mmio_req.addr == ADDR_TB_REF1) begin
                st_nxt.mmio_rsp.rdata = kp_r.ref1;
            end else if (mmio_req.addr == ADDR_RTC_CSR) begin
                st_nxt.mmio_rsp.rdata = {16'h0000, rtc_csr_rd};
            end else if (mmio_req.addr == ADDR_RTC_COUNT) begin
                st_nxt.mmio_rsp.rdata = kp_r.rtc_cnt;
            end else if (mmio_req.addr == ADDR_RTC_ALARM) begin
                st_nxt.mmio_rsp.rdata = kp_r.rtc_alarm;
            end
        end

        // special-purpose register port; software writes override counting
        st_nxt.trap = 1'b0;
        st_nxt.spr_rsp.rvalid = sp_rd;
        st_nxt.spr_rsp.rdata = 32'h0000_0000;
        if (sp_wr) begin
            if (spr_req.num == SPR_TB_LO_WR) begin
                kp_nxt.tb[31:0] = spr_req.wdata;
            end else if (spr_req.num == SPR_TB_HI_WR) begin
                kp_nxt.tb[63:32] = spr_req.wdata;
            end else if (spr_req.num == SPR_DOWN_COUNTER) begin
                kp_nxt.dec = spr_req.wdata;
                st_nxt.dec_loaded = 1'b1;
            end else if (spr_req.num == SPR_TB_LO_RD || spr_req.num == SPR_TB_HI_RD) begin
                st_nxt.trap = 1'b1;
            end
        end else if (sp_rd) begin
            if (spr_req.num == SPR_TB_LO_RD) begin
                st_nxt.spr_rsp.rdata = kp_r.tb[31:0];
            end else if (spr_req.num == SPR_TB_HI_RD) begin
                st_nxt.spr_rsp.rdata = kp_r.tb[63:32];
            end else if (spr_req.num == SPR_DOWN_COUNTER) begin
                st_nxt.spr_rsp.rdata = kp_r.dec;
            end else if (spr_req.num == SPR_TB_LO_WR || spr_req.num == SPR_TB_HI_WR) begin
                st_nxt.trap = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // keep-alive registers have no reset
    always_ff @(posedge sys_clk) begin
        kp_r <= kp_nxt;
    end

    assign mmio_rsp = st_r.mmio_rsp;
    assign spr_rsp = st_r.spr_rsp;
    assign spr_emul_trap = st_r.trap;
    assign dec_irq = st_r.dec_irq;
    assign insn_is_move_from_tb = (insn_xop == XOP_MOVE_FROM_TB);
    assign insn_is_move_from_spr = (insn_xop == XOP_MOVE_FROM_SPR);
    assign tb_irq_level = req_level(st_r.tb_lvl, (st_r.m0 & st_r.ie0) | (st_r.m1 & st_r.ie1));
    assign rtc_irq_level = req_level(st_r.rtc_lvl, (st_r.sec & st_r.tick_irq_enable) | (st_r.alarm_match_flag & st_r.ale));

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_dec_irq;
        tb_tick && st_r.dec_loaded && !kp_r.dec[31] && dec_dn[31] && !sp_wr |=> dec_irq && kp_r.dec[31];
    endproperty
    a_dec_irq: assert property (p_dec_irq) else $error("down counter wrap gave no interrupt");

    property p_dec_read;
        sp_rd && spr_req.num == SPR_DOWN_COUNTER |=> spr_rsp.rvalid && spr_rsp.rdata == $past(kp_r.dec);
    endproperty
    a_dec_read: assert property (p_dec_read) else $error("down counter read not live");

    property p_tb_hold;
        !tb_run && !sp_wr |=> $stable(kp_r.tb) && $stable(kp_r.dec);
    endproperty
    a_tb_hold: assert property (p_tb_hold) else $error("timebase moved while stopped");

    property p_tb_inc;
        tb_tick && !sp_wr |=> kp_r.tb == $past(kp_r.tb) + 64'h0000_0000_0000_0001;
    endproperty
    a_tb_inc: assert property (p_tb_inc) else $error("timebase missed a tick");

    property p_tb_write_lo;
        sp_wr && spr_req.num == SPR_TB_LO_WR |=> kp_r.tb[31:0] == $past(spr_req.wdata);
    endproperty
    a_tb_write_lo: assert property (p_tb_write_lo) else $error("lower timebase write lost");

    property p_trap;
        sp_wr && (spr_req.num == SPR_TB_LO_RD || spr_req.num == SPR_TB_HI_RD) && !tb_tick
            |=> spr_emul_trap && $stable(kp_r.tb);
    endproperty
    a_trap: assert property (p_trap) else $error("wrong-direction access not trapped");

    property p_match0;
        match0 |=> st_r.m0;
    endproperty
    a_match0: assert property (p_match0) else $error("reference 0 match flag not set");

    property p_w1c;
        mm_wr && mmio_req.addr == ADDR_TB_CSR && mmio_req.wdata[CSR_FLAG1] && !match1 |=> !st_r.m1;
    endproperty
    a_w1c: assert property (p_w1c) else $error("match flag not cleared by one");

    property p_tb_irq;
        st_r.m0 && st_r.ie0 |-> tb_irq_level == st_r.tb_lvl;
    endproperty
    a_tb_irq: assert property (p_tb_irq) else $error("timebase request level wrong");

    property p_sec;
        sec_pulse |=> st_r.sec ##0 kp_r.prescale == 16'h0000;
    endproperty
    a_sec: assert property (p_sec) else $error("second pulse not flagged");

    property p_rtc_irq;
        st_r.alarm_match_flag && st_r.ale |-> rtc_irq_level == st_r.rtc_lvl;
    endproperty
    a_rtc_irq: assert property (p_rtc_irq) else $error("alarm request level wrong");

    property p_dec_load;
        sp_wr && spr_req.num == SPR_DOWN_COUNTER |=> kp_r.dec == $past(spr_req.wdata);
    endproperty
    a_dec_load: assert property (p_dec_load) else $error("down counter write lost");

    property p_tb_write_hi;
        sp_wr && spr_req.num == SPR_TB_HI_WR |=> kp_r.tb[63:32] == $past(spr_req.wdata);
    endproperty
    a_tb_write_hi: assert property (p_tb_write_hi) else $error("upper timebase write lost");

    property p_trap_read;
        sp_rd && (spr_req.num == SPR_TB_LO_WR || spr_req.num == SPR_TB_HI_WR)
            |=> spr_emul_trap && spr_rsp.rvalid && spr_rsp.rdata == 32'h0000_0000;
    endproperty
    a_trap_read: assert property (p_trap_read) else $error("read of write number not trapped");

    property p_alarm;
        alarm_hit |=> st_r.alarm_match_flag;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm match not flagged");

    property p_tb_irq_off;
        !(st_r.m0 && st_r.ie0) && !(st_r.m1 && st_r.ie1) |-> tb_irq_level == 8'h00;
    endproperty
    a_tb_irq_off: assert property (p_tb_irq_off) else $error("timebase request without cause");
endmodule : stb_timers

// ==== core/stb_pkg.sv ====
package stb_pkg;
    // memory-mapped offsets of the timer registers
    localparam logic [11:0] ADDR_TB_CSR = 12'h200;
    localparam logic [11:0] ADDR_TB_REF0 = 12'h204;
    localparam logic [11:0] ADDR_TB_REF1 = 12'h208;
    localparam logic [11:0] ADDR_RTC_CSR = 12'h220;
    localparam logic [11:0] ADDR_RTC_COUNT = 12'h224;
    localparam logic [11:0] ADDR_RTC_ALARM = 12'h228;

    // special-purpose register numbers of the timebase
    localparam logic [9:0] SPR_TB_LO_RD = 10'h10c;
    localparam logic [9:0] SPR_TB_HI_RD = 10'h10d;
    localparam logic [9:0] SPR_TB_LO_WR = 10'h11c;
    localparam logic [9:0] SPR_TB_HI_WR = 10'h11d;
    // down counter number, value arbitrary
    localparam logic [9:0] SPR_DOWN_COUNTER_DEFAULT = 10'h3e8;

    // extended opcodes of the two read instructions
    localparam logic [9:0] XOP_MOVE_FROM_TB = 10'h173;
    localparam logic [9:0] XOP_MOVE_FROM_SPR = 10'h153;

    // field positions, shared by both control/status registers except source select, which only the clock one has
    localparam int CSR_LVL_LSB = 8;
    localparam int CSR_FLAG0 = 7;
    localparam int CSR_FLAG1 = 6;
    localparam int CSR_SRC_SEL = 4;
    localparam int CSR_IE0 = 3;
    localparam int CSR_IE1 = 2;
    localparam int CSR_FRZ = 1;
    localparam int CSR_EN = 0;
    localparam logic [7:0] LVL_RESET = 8'h00;

    // real-time clock input rates in Hz
    localparam int RTC_HZ_SLOW = 32768;
    localparam int RTC_HZ_FAST = 38400;
    localparam logic [15:0] RTC_DIV_SLOW = 16'(RTC_HZ_SLOW - 1);
    localparam logic [15:0] RTC_DIV_FAST = 16'(RTC_HZ_FAST - 1);

    localparam int TB_TICK_DIV_DEFAULT = 4;
    localparam int TICK_CNT_W = 16;

    typedef struct packed {
        logic valid;
        logic write;
        logic [11:0] addr;
        logic [31:0] wdata;
    } stb_mmio_req_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [9:0] num;
        logic [31:0] wdata;
    } stb_spr_req_type;

    typedef struct packed {
        logic rvalid;
        logic [31:0] rdata;
    } stb_rsp_type;
endpackage : stb_pkg

// ==== verification/stb_timers_tb.sv ====
`timescale 1ns/1ps
module stb_timers_tb;
    import stb_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic debug_freeze = 1'b0;
    logic rtc_clk_pin = 1'b0;
    logic [9:0] insn_xop = 10'h000;
    stb_mmio_req_type mmio_req = '0;
    stb_spr_req_type spr_req = '0;
    stb_rsp_type mmio_rsp;
    stb_rsp_type spr_rsp;
    logic spr_emul_trap;
    logic insn_is_move_from_tb;
    logic insn_is_move_from_spr;
    logic dec_irq;
    logic [7:0] tb_irq_level;
    logic [7:0] rtc_irq_level;
    int bad_count = 0;
    int checks = 0;
    int dec_hits = 0;
    int seed = 69779;
    logic [31:0] rd;
    logic [31:0] v1;
    logic [31:0] v2;
    logic [31:0] r0;
    logic tr;

    stb_timers #(.TB_TICK_DIV(1)) u_dut (
        .sys_clk(sys_clk),
        .rst(rst),
        .debug_freeze(debug_freeze),
        .rtc_clk_pin(rtc_clk_pin),
        .mmio_req(mmio_req),
        .mmio_rsp(mmio_rsp),
        .spr_req(spr_req),
        .spr_rsp(spr_rsp),
        .spr_emul_trap(spr_emul_trap),
        .insn_xop(insn_xop),
        .insn_is_move_from_tb(insn_is_move_from_tb),
        .insn_is_move_from_spr(insn_is_move_from_spr),
        .dec_irq(dec_irq),
        .tb_irq_level(tb_irq_level),
        .rtc_irq_level(rtc_irq_level)
    );

    always #5 sys_clk = ~sys_clk;

    // keep-alive input wanders so the synchroniser always sees traffic
    always @(posedge sys_clk) begin
        rtc_clk_pin <= 1'($random(seed));
        if (dec_irq === 1'b1) begin
            dec_hits++;
        end
    end

    task check(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task complete_run;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task mmio(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        mmio_req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
        @(posedge sys_clk);
        mmio_req <= '0;
        #1;
        rd = mmio_rsp.rdata;
        if (!w) begin
            check(mmio_rsp.rvalid, 1'b1);
        end
    endtask : mmio

    task spr(input logic w, input logic [9:0] n, input logic [31:0] d);
        @(posedge sys_clk);
        spr_req <= '{valid: 1'b1, write: w, num: n, wdata: d};
        @(posedge sys_clk);
        spr_req <= '0;
        #1;
        rd = spr_rsp.rdata;
        tr = spr_emul_trap;
    endtask : spr

    task do_reset;
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check({tb_irq_level, rtc_irq_level, dec_irq}, 17'h0);
        @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_reset

    initial begin
        #100000;
        bad_count++;
        complete_run();
    end

    initial begin
        do_reset();
        // instruction decode of both read forms
        @(posedge sys_clk);
        insn_xop <= 10'h173;
        @(negedge sys_clk);
        check({insn_is_move_from_tb, insn_is_move_from_spr}, 2'b10);
        @(posedge sys_clk);
        insn_xop <= 10'h153;
        @(negedge sys_clk);
        check({insn_is_move_from_tb, insn_is_move_from_spr}, 2'b01);
        // software load of a stopped timebase
        mmio(1'b1, 12'h200, 32'h0);
        v1 = $random(seed);
        v2 = $random(seed);
        spr(1'b1, 10'h11c, v1);
        spr(1'b1, 10'h11d, v2);
        spr(1'b0, 10'h10c, 32'h0);
        check(rd, v1);
        spr(1'b0, 10'h10d, 32'h0);
        check({tr, rd}, {1'b0, v2});
        // wrong-direction accesses
        spr(1'b1, 10'h10c, ~v1);
        check(tr, 1'b1);
        spr(1'b0, 10'h11c, 32'h0);
        check({tr, rd}, {1'b1, 32'h0});
        spr(1'b0, 10'h10c, 32'h0);
        check(rd, v1);
        // freeze while debugging, then release
        @(posedge sys_clk);
        debug_freeze <= 1'b1;
        mmio(1'b1, 12'h200, 32'h3);
        spr(1'b0, 10'h10c, 32'h0);
        check(rd, v1);
        @(posedge sys_clk);
        debug_freeze <= 1'b0;
        spr(1'b0, 10'h10c, 32'h0);
        check(rd !== v1, 1'b1);
        // down counter crosses zero while counting
        mmio(1'b1, 12'h200, 32'h1);
        dec_hits = 0;
        spr(1'b1, SPR_DOWN_COUNTER_DEFAULT, 32'h3);
        for (int i = 0; i < 50 && dec_hits == 0; i++) begin
            @(posedge sys_clk);
        end
        repeat (10) @(posedge sys_clk);
        check(dec_hits, 1);
        spr(1'b0, SPR_DOWN_COUNTER_DEFAULT, 32'h0);
        check(rd[31], 1'b1);
        mmio(1'b1, 12'h200, 32'h0);
        spr(1'b0, SPR_DOWN_COUNTER_DEFAULT, 32'h0);
        v1 = rd;
        spr(1'b0, SPR_DOWN_COUNTER_DEFAULT, 32'h0);
        check(rd, v1);
        do_reset();
        spr(1'b0, SPR_DOWN_COUNTER_DEFAULT, 32'h0);
        check(rd, v1);
        // reference comparators against a stopped timebase
        r0 = $random(seed);
        mmio(1'b1, 12'h204, r0);
        mmio(1'b1, 12'h208, r0 + 32'h5);
        mmio(1'b0, 12'h204, 32'h0);
        check(rd, r0);
        mmio(1'b0, 12'h208, 32'h0);
        check(rd, r0 + 32'h5);
        // also clears match flags left unknown while the references were unwritten
        mmio(1'b1, 12'h200, 32'h20c8);
        spr(1'b1, 10'h11c, r0);
        mmio(1'b0, 12'h200, 32'h0);
        check(rd, 32'h2088);
        check(tb_irq_level, 8'h20);
        spr(1'b1, 10'h11c, r0 + 32'h5);
        mmio(1'b0, 12'h200, 32'h0);
        check(rd, 32'h20c8);
        mmio(1'b1, 12'h200, 32'h2004);
        mmio(1'b0, 12'h200, 32'h0);
        check({rd, tb_irq_level}, {32'h20c4, 8'h20});
        mmio(1'b1, 12'h200, 32'h2000);
        check(tb_irq_level, 8'h00);
        spr(1'b1, 10'h11c, r0 + 32'h9);
        mmio(1'b1, 12'h200, 32'h20c4);
        mmio(1'b0, 12'h200, 32'h0);
        check({rd, tb_irq_level}, {32'h2004, 8'h00});
        // clock control: fields read back, source and enable survive reset
        mmio(1'b1, 12'h224, 32'h0);
        mmio(1'b1, 12'h228, 32'hffff_ffff);
        mmio(1'b1, 12'h220, 32'h4019);
        mmio(1'b0, 12'h220, 32'h0);
        check({rd, rtc_irq_level}, {32'h4019, 8'h00});
        do_reset();
        mmio(1'b0, 12'h220, 32'h0);
        check(rd, 32'h0011);
        complete_run();
    end
endmodule : stb_timers_tb
